// >>> common/pwst_consts.svh
// offsets, field positions, reset values and counts for the pwm status block
// assumes inclusion by bare name from the design files
`ifndef PWST_CONSTS_SVH
`define PWST_CONSTS_SVH
`define PWST_OFF_PASSIVE 16'he8c4
`define PWST_OFF_STATUS 16'he8d0
`define PWST_OFF_SET 16'he8d2
`define PWST_OFF_CLEAR 16'he8d4
`define PWST_OFF_ENABLE 16'he8d6
`define PWST_OFF_NODE 16'he8d8
`define PWST_OFF_CTRL 16'he8da
`define PWST_OFF_OUTCFG 16'he8dc
`define PWST_BIT_AUX_PSL 7
`define PWST_BIT_IDLE 14
`define PWST_BIT_WHE 13
`define PWST_BIT_CHE 12
`define PWST_BIT_TRAP_STATE_BIT 11
`define PWST_BIT_TRAP_FLAG 10
`define PWST_BIT_AUXPM 9
`define PWST_BIT_AUXCM 8
`define PWST_BIT_MAINPM 7
`define PWST_BIT_MAINOM 6
`define PWST_BIT_CTRL_PEN 0
`define PWST_BIT_CTRL_SW 1
`define PWST_BIT_CTRL_SYNC 2
`define PWST_BIT_CTRL_ASTOP 4
`define PWST_RST_16 16'h0000
`define PWST_STATUS_MASK 16'h7fff
`define PWST_SET_MASK 16'h77ff
`define PWST_NSRC 14
`define PWST_NLINE 4
`endif

// >>> common/pwst_pkg.sv
// types shared by the pwm status block files
// assumes the constants header is compiled alongside
package pwst_pkg;
  typedef logic [15:0] pwst_word_t;
  typedef enum logic [2:0] {
    PWST_IDLE = 3'b001,
    PWST_WAIT = 3'b010,
    PWST_DONE = 3'b100
  } pwst_bus_e;
endpackage

// >>> hw/pwst_line_merge.sv
// one request line: ors the enabled pulses whose node pointer selects it
// assumes pulses and pointers are on the same clock as the caller
`timescale 1ns/1ns
`default_nettype none
`include "pwst_consts.svh"
module pwst_line_merge #(
  parameter logic [1:0] LINE = 2'h0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [`PWST_NSRC-1:0] pulse,
  input wire logic [2*`PWST_NSRC-1:0] node,
  output logic req_q
);
  logic hit;
  int i;
  // collect all sources routed here onto one line
  always_comb begin
    hit = 1'b0;
    for (i = 0; i < `PWST_NSRC; i++) begin
      if (pulse[i] && node[2*i +: 2] == LINE) begin
        hit = 1'b1;
      end
    end
  end
  // one cycle per event since pulses are single-cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      req_q <= 1'b0;
    end else begin
      req_q <= hit;
    end
  end
endmodule // pwst_line_merge
`default_nettype wire

// >>> hw/pwst_top.sv
// pwm unit status flags, passive levels, trap state and request lines
// assumes timer events are one-cycle pulses on CLK_SYS; trap and hall pins are async
//
// Contract
// - output is passive level, inverted when active
// - bit 7 sets aux output passive level
// - bits 5..0 map ch2,ch1,ch0 complement/direct
// - level writes go to shadow, transfer event
// - per-period parameters are double buffered
// - hardware event or set write sets flag
// - pulse comes from event, not flag
// - clear register write clears flag
// - enabled source pulses its pointed line
// - sources sharing a line are merged
// - status register ignores bus writes
// - stop flag set with wrong hall
// - stop flag clears pattern, forces passive
// - bit 13 on wrong hall pattern
// - bit 12 on expected hall pattern
// - trap state follows trap flag, mode exit
// - trap state exit by sync mode code
// - trap flag set by software or pin
// - trap flag hardware or software exit
// - bits 9 and 8 aux period/compare
// - bit 7 main period while up
// - bit 6 main one while down
// - bits 5..0: odd falling/down, even rising/up flags
// - set and clear read zero, 1 acts
`timescale 1ns/1ns
`default_nettype none
`include "pwst_consts.svh"
module pwst_top (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic [15:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic TRAP_INPUT_N,
  input wire logic HALL_WRONG,
  input wire logic HALL_CORRECT,
  input wire logic MAIN_PERIOD_MATCH,
  input wire logic MAIN_ONE_MATCH,
  input wire logic MAIN_COUNT_UP,
  input wire logic MAIN_ZERO_MATCH,
  input wire logic AUX_ZERO_MATCH,
  input wire logic AUX_PERIOD_MATCH,
  input wire logic AUX_COMPARE_MATCH,
  input wire logic MAIN_SHADOW_TRANSFER,
  input wire logic [2:0] CH_MATCH,
  input wire logic [2:0] CH_FALL_CAPTURE,
  input wire logic [2:0] CH_RISE_CAPTURE,
  input wire logic [6:0] OUT_ACTIVE,
  output logic [6:0] PIN_OUT,
  output logic [5:0] MULTICHANNEL_PATTERN,
  output logic [3:0] REQUEST_LINE
);
  pwst_pkg::pwst_bus_e bus_q;
  logic [15:0] psl_q, psl_shadow_q, status_q, enable_q, ctrl_q, multichannel_pattern_q;
  logic [27:0] node_q;
  logic [15:0] hw_ev, sw_set, sw_clr;
  logic [1:0] trap_sync_q;
  logic [2:0] hall_w_sync_q, hall_c_sync_q;
  logic trap_low, wrong_ev, correct_ev, trap_flag_hw_clr, trap_state_bit_exit;
  logic [`PWST_NSRC-1:0] src_pulse;
  logic [3:0] req_w;
  logic wr_hit;
  logic [15:0] wdat;

  //////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, answer on the second edge
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      bus_q <= pwst_pkg::PWST_IDLE;
    end else begin
      case (bus_q)
        pwst_pkg::PWST_IDLE: if (AVS_READ || AVS_WRITE) bus_q <= pwst_pkg::PWST_WAIT;
        pwst_pkg::PWST_WAIT: bus_q <= pwst_pkg::PWST_DONE;
        default: bus_q <= pwst_pkg::PWST_IDLE;
      endcase
    end
  end
  // waitrequest low only in the done state while a read or write is asserted, so the master releases after it
  assign AVS_WAITREQUEST = (bus_q != pwst_pkg::PWST_DONE) || !(AVS_READ || AVS_WRITE);
  assign wr_hit = (bus_q == pwst_pkg::PWST_WAIT) && AVS_WRITE;
  assign wdat = AVS_WRITEDATA[15:0];

  // read mux registered in the wait cycle; unmapped reads zero
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      AVS_READDATA <= 32'h00000000;
    end else if (bus_q == pwst_pkg::PWST_WAIT && AVS_READ) begin
      if (AVS_ADDRESS == `PWST_OFF_PASSIVE) AVS_READDATA <= {16'h0000, psl_q};
      else if (AVS_ADDRESS == `PWST_OFF_STATUS) AVS_READDATA <= {16'h0000, status_q};
      else if (AVS_ADDRESS == `PWST_OFF_ENABLE) AVS_READDATA <= {16'h0000, enable_q};
      else if (AVS_ADDRESS == `PWST_OFF_NODE) AVS_READDATA <= {4'h0, node_q};
      else if (AVS_ADDRESS == `PWST_OFF_CTRL) AVS_READDATA <= {16'h0000, ctrl_q};
      else AVS_READDATA <= 32'h00000000;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      enable_q <= `PWST_RST_16;
      node_q <= 28'h0000000;
      ctrl_q <= `PWST_RST_16;
    end else if (wr_hit) begin
      if (AVS_ADDRESS == `PWST_OFF_ENABLE) enable_q <= wdat & `PWST_SET_MASK;
      else if (AVS_ADDRESS == `PWST_OFF_NODE) node_q <= AVS_WRITEDATA[27:0];
      else if (AVS_ADDRESS == `PWST_OFF_CTRL) ctrl_q <= wdat & 16'h001f;
    end
  end

  // writes land in shadow, used copy moves on transfer
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      psl_shadow_q <= `PWST_RST_16;
      psl_q <= `PWST_RST_16;
    end else begin
      if (wr_hit && AVS_ADDRESS == `PWST_OFF_PASSIVE) psl_shadow_q <= wdat & 16'h00bf;
      if (MAIN_SHADOW_TRANSFER) psl_q <= psl_shadow_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers: stage 0 feeds stage 1 only; stage 2 gives edges
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      trap_sync_q <= 2'h3;
      hall_w_sync_q <= 3'h0;
      hall_c_sync_q <= 3'h0;
    end else begin
      trap_sync_q <= {trap_sync_q[0], TRAP_INPUT_N};
      hall_w_sync_q <= {hall_w_sync_q[1:0], HALL_WRONG};
      hall_c_sync_q <= {hall_c_sync_q[1:0], HALL_CORRECT};
    end
  end
  assign trap_low = !trap_sync_q[1];
  // transitions to wrong or expected pattern
  assign wrong_ev = hall_w_sync_q[1] && !hall_w_sync_q[2];
  assign correct_ev = hall_c_sync_q[1] && !hall_c_sync_q[2];

  //////////////////////////////////////////////////////////////////////////
  // hardware event vector aligned with status bits
  always_comb begin
    hw_ev = 16'h0000;
    hw_ev[5] = (CH_MATCH[2] && !MAIN_COUNT_UP) || CH_FALL_CAPTURE[2];
    hw_ev[4] = (CH_MATCH[2] && MAIN_COUNT_UP) || CH_RISE_CAPTURE[2];
    hw_ev[3] = (CH_MATCH[1] && !MAIN_COUNT_UP) || CH_FALL_CAPTURE[1];
    hw_ev[2] = (CH_MATCH[1] && MAIN_COUNT_UP) || CH_RISE_CAPTURE[1];
    hw_ev[1] = (CH_MATCH[0] && !MAIN_COUNT_UP) || CH_FALL_CAPTURE[0];
    hw_ev[0] = (CH_MATCH[0] && MAIN_COUNT_UP) || CH_RISE_CAPTURE[0];
    hw_ev[`PWST_BIT_MAINOM] = MAIN_ONE_MATCH && !MAIN_COUNT_UP;
    hw_ev[`PWST_BIT_MAINPM] = MAIN_PERIOD_MATCH && MAIN_COUNT_UP;
    hw_ev[`PWST_BIT_AUXCM] = AUX_COMPARE_MATCH;
    hw_ev[`PWST_BIT_AUXPM] = AUX_PERIOD_MATCH;
    hw_ev[`PWST_BIT_TRAP_FLAG] = ctrl_q[`PWST_BIT_CTRL_PEN] && trap_low;
    hw_ev[`PWST_BIT_CHE] = correct_ev;
    hw_ev[`PWST_BIT_WHE] = wrong_ev;
    hw_ev[`PWST_BIT_IDLE] = wrong_ev && ctrl_q[`PWST_BIT_CTRL_ASTOP];
  end

  assign sw_set = (wr_hit && AVS_ADDRESS == `PWST_OFF_SET) ? (wdat & `PWST_SET_MASK) : 16'h0000;
  assign sw_clr = (wr_hit && AVS_ADDRESS == `PWST_OFF_CLEAR) ? (wdat & `PWST_SET_MASK) : 16'h0000;
  // hardware exit when pin released and software exit off
  assign trap_flag_hw_clr = !ctrl_q[`PWST_BIT_CTRL_SW] && !trap_low;
  // sync mode: 00 main zero, 01 aux zero, 11 now, 10 nothing
  assign trap_state_bit_exit = (ctrl_q[3:2] == 2'h0 && MAIN_ZERO_MATCH) ||
                     (ctrl_q[3:2] == 2'h1 && AUX_ZERO_MATCH) || (ctrl_q[3:2] == 2'h3);

  //////////////////////////////////////////////////////////////////////////
  // status ignores bus writes; set wins over clear
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      status_q <= `PWST_RST_16;
    end else begin
      // event or set write, clear write
      status_q[10:0] <= (status_q[10:0] & ~sw_clr[10:0]) | hw_ev[10:0] | sw_set[10:0];
      status_q[14:12] <= (status_q[14:12] & ~sw_clr[14:12]) | hw_ev[14:12] | sw_set[14:12];
      status_q[15] <= 1'b0;
      if (trap_flag_hw_clr && !hw_ev[`PWST_BIT_TRAP_FLAG] && !sw_set[`PWST_BIT_TRAP_FLAG])
        status_q[`PWST_BIT_TRAP_FLAG] <= 1'b0;
      // trap state held while flag set
      if (status_q[`PWST_BIT_TRAP_FLAG]) status_q[`PWST_BIT_TRAP_STATE_BIT] <= 1'b1;
      else if (trap_state_bit_exit) status_q[`PWST_BIT_TRAP_STATE_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      multichannel_pattern_q <= `PWST_RST_16;
    end else if (status_q[`PWST_BIT_IDLE]) begin
      multichannel_pattern_q <= 16'h0000;
    end else if (wr_hit && AVS_ADDRESS == `PWST_OFF_OUTCFG) begin
      multichannel_pattern_q <= wdat & 16'h003f;
    end
  end
  assign MULTICHANNEL_PATTERN = multichannel_pattern_q[5:0];

  //////////////////////////////////////////////////////////////////////////
  // level select; trap or stop forces passive
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      PIN_OUT <= 7'h00;
    end else begin
      // forced passive while stopped or trapped
      if (status_q[`PWST_BIT_IDLE] || status_q[`PWST_BIT_TRAP_STATE_BIT])
        PIN_OUT <= {psl_q[`PWST_BIT_AUX_PSL], psl_q[5:0]};
      else
        PIN_OUT <= {psl_q[`PWST_BIT_AUX_PSL], psl_q[5:0]} ^ OUT_ACTIVE;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pulses from event itself, flag state ignored
  assign src_pulse = {hw_ev[14:12], hw_ev[10:0]} | {sw_set[14:12], sw_set[10:0]};

  genvar g;
  generate
    for (g = 0; g < `PWST_NLINE; g++) begin : g_line
      pwst_line_merge #(.LINE(2'(g))) u_line (
        .clk(CLK_SYS),
        .reset_n(RESET_N),
        .pulse(src_pulse & {enable_q[14:12], enable_q[10:0]}),
        .node(node_q),
        .req_q(req_w[g])
      );
    end
  endgenerate
  assign REQUEST_LINE = req_w;

  //////////////////////////////////////////////////////////////////////////
  // checks
  status_ro_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (wr_hit && AVS_ADDRESS == `PWST_OFF_STATUS && hw_ev == 16'h0 && !status_q[10])
    |=> status_q[9:0] == $past(status_q[9:0]))
    else $error("status changed by bus write");
  set_reg_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    sw_set[`PWST_BIT_AUXPM] |=> status_q[`PWST_BIT_AUXPM])
    else $error("set write did not set flag");
  clr_reg_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (sw_clr[`PWST_BIT_CHE] && !hw_ev[`PWST_BIT_CHE] && !sw_set[`PWST_BIT_CHE])
    |=> !status_q[`PWST_BIT_CHE])
    else $error("clear write did not clear flag");
  shadow_xfer_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    !MAIN_SHADOW_TRANSFER |=> psl_q == $past(psl_q))
    else $error("levels changed without transfer");
  stop_pattern_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    status_q[`PWST_BIT_IDLE] |=> multichannel_pattern_q == 16'h0)
    else $error("pattern not cleared while stopped");
  stop_hall_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (wrong_ev && ctrl_q[`PWST_BIT_CTRL_ASTOP]) |=> status_q[14:13] == 2'h3)
    else $error("stop flag not set with wrong hall");
  period_up_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (MAIN_PERIOD_MATCH && !MAIN_COUNT_UP && !sw_set[7] && !status_q[7]) |=> !status_q[7])
    else $error("period flag set while counting down");
  trap_state_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    status_q[`PWST_BIT_TRAP_FLAG] |=> status_q[`PWST_BIT_TRAP_STATE_BIT])
    else $error("trap state not set under trap flag");
  pulse_one_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (src_pulse[7] && enable_q[7] && node_q[15:14] == 2'h2) |=> REQUEST_LINE[2])
    else $error("request pulse missing");
  passive_pin_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    status_q[`PWST_BIT_TRAP_STATE_BIT] |=> PIN_OUT == {$past(psl_q[7]), $past(psl_q[5:0])})
    else $error("pin not at passive level");
endmodule // pwst_top
`default_nettype wire

// >>> test/pwst_irq_sink.sv
// stand-in for the processor interrupt controller: counts request pulses
// assumes request lines are registered pulses on the same clock
`timescale 1ns/1ns
`default_nettype none
module pwst_irq_sink (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] req,
  output logic [3:0][7:0] cnt_q,
  output logic wide_q
);
  logic [3:0] req_q;
  ////////////////////////////////////////
  // count rising edges per line; a line high two cycles running is flagged
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_q <= '0;
      wide_q <= 1'b0;
      req_q <= 4'h0;
    end else begin
      req_q <= req;
      for (int i = 0; i < 4; i++) begin
        if (req[i] && !req_q[i]) cnt_q[i] <= cnt_q[i] + 8'h01;
      end
      if (|(req & req_q)) wide_q <= 1'b1;
    end
  end
endmodule // pwst_irq_sink
`default_nettype wire

// >>> test/pwm_unit_status_and_output_level_tb_top.sv
// self-checking bench for the pwm status block: bus, events, traps, hall
// assumes the design answers avalon requests and the sink counts pulses
`timescale 1ns/1ns
`default_nettype none
`include "pwst_consts.svh"
module pwm_unit_status_and_output_level_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wait_req;
  logic trap_n = 1'b1;
  logic hall_w = 1'b0;
  logic hall_c = 1'b0;
  logic up = 1'b1;
  logic [15:0] ev = 16'h0000;
  logic [6:0] act = 7'h00;
  logic [6:0] pin;
  logic [5:0] pat;
  logic [3:0] req;
  logic [3:0][7:0] cnt;
  logic wide;
  int n_fail = 0;
  int comparisons = 0;
  pwst_pkg::pwst_word_t r, v, main_outputs_passive_level;
  int ln, zr, b_ln, b_all;
  int md[4] = '{0, 1, 3, 2};
  pwst_top DUT (.CLK_SYS(clk), .RESET_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_req),
    .TRAP_INPUT_N(trap_n), .HALL_WRONG(hall_w), .HALL_CORRECT(hall_c),
    .MAIN_PERIOD_MATCH(ev[0]), .MAIN_ONE_MATCH(ev[1]), .MAIN_COUNT_UP(up),
    .MAIN_ZERO_MATCH(ev[2]), .AUX_ZERO_MATCH(ev[3]), .AUX_PERIOD_MATCH(ev[4]),
    .AUX_COMPARE_MATCH(ev[5]), .MAIN_SHADOW_TRANSFER(ev[6]), .CH_MATCH(ev[9:7]),
    .CH_FALL_CAPTURE(ev[12:10]), .CH_RISE_CAPTURE(ev[15:13]), .OUT_ACTIVE(act),
    .PIN_OUT(pin), .MULTICHANNEL_PATTERN(pat), .REQUEST_LINE(req));
  pwst_irq_sink sink (.clk(clk), .reset_n(rst_n), .req(req), .cnt_q(cnt), .wide_q(wide));
  ////////////////////////////////////////
  // clock at 100 MHz
  initial begin
    forever #5 clk = ~clk;
  end
  // verdict and end of run
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one avalon transfer; held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [15:0] q);
    int k;
    @(posedge clk);
    addr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    k = 0;
    // sample waitrequest and read data at rising edges only
    do begin
      @(posedge clk);
      k++;
    end while (wait_req !== 1'b0 && k < 50);
    if (k >= 50) begin
      n_fail++;
      test_done();
    end
    q = rdat[15:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wreg(input logic [15:0] a, input logic [31:0] d);
    logic [15:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev <= 16'h0000;
  endtask
  // flag expected from one event line and the count direction
  function automatic pwst_pkg::pwst_word_t exp_ev(input int i, input logic u);
    if (i == 0) return u ? 16'h0080 : 16'h0000;
    if (i == 1) return 16'h0040;
    if (i == 4) return 16'h0200;
    if (i == 5) return 16'h0100;
    if (i < 10) return 16'h0001 << (2 * (i - 7) + (u ? 0 : 1));
    if (i < 13) return 16'h0002 << (2 * (i - 10));
    return 16'h0001 << (2 * (i - 13));
  endfunction
  function automatic pwst_pkg::pwst_word_t exp_pin(input logic [15:0] p, input logic [6:0] a);
    return {9'h000, p[7] ^ a[6], p[5:0] ^ a[5:0]};
  endfunction
  ////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(32'h207c));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rchk(`PWST_OFF_PASSIVE, 16'h0000);
    wreg(`PWST_OFF_STATUS, 32'hffff);
    rchk(`PWST_OFF_STATUS, 16'h0000);
    r = 16'($urandom()) & 16'h03ff;
    wreg(`PWST_OFF_SET, {16'h0, r});
    rchk(`PWST_OFF_STATUS, r);
    rchk(`PWST_OFF_SET, 16'h0000);
    rchk(`PWST_OFF_CLEAR, 16'h0000);
    v = 16'($urandom()) & 16'h03ff;
    wreg(`PWST_OFF_CLEAR, {16'h0, v});
    rchk(`PWST_OFF_STATUS, r & ~v);
    // every event line except 2, 3 and 6, counting direction drawn at random except down for line 1
    for (int i = 0; i < 16; i++) begin
      if (i == 2 || i == 3 || i == 6) continue;
      wreg(`PWST_OFF_CLEAR, 32'h7fff);
      up <= (i == 1) ? 1'b0 : 1'($urandom());
      pulse(i);
      rchk(`PWST_OFF_STATUS, exp_ev(i, up));
    end
    // two enabled sources and one disabled all pointed at one line
    ln = $urandom_range(3);
    wreg(`PWST_OFF_ENABLE, 32'h0280);
    wreg(`PWST_OFF_NODE, (ln << 14) | (ln << 16) | (ln << 18));
    b_ln = cnt[ln];
    b_all = cnt[0] + cnt[1] + cnt[2] + cnt[3];
    up <= 1'b1;
    wreg(`PWST_OFF_SET, 32'h0080);
    @(posedge clk);
    ev[0] <= 1'b1;
    ev[4] <= 1'b1;
    ev[5] <= 1'b1;
    @(posedge clk);
    ev <= 16'h0000;
    cyc(4);
    chk(16'(cnt[ln] - b_ln), 16'h0002);
    chk(16'(cnt[0] + cnt[1] + cnt[2] + cnt[3] - b_all), 16'h0002);
    chk({15'h0, wide}, 16'h0000);
    // passive levels go through the shadow copy
    main_outputs_passive_level = 16'($urandom()) & 16'h00bf;
    wreg(`PWST_OFF_PASSIVE, {16'h0, main_outputs_passive_level});
    rchk(`PWST_OFF_PASSIVE, 16'h0000);
    pulse(6);
    rchk(`PWST_OFF_PASSIVE, main_outputs_passive_level);
    for (int j = 0; j < 4; j++) begin
      act <= 7'($urandom());
      cyc(3);
      chk({9'h000, pin}, exp_pin(main_outputs_passive_level, act));
    end
    // trap entry and exit for each sync code, reserved code last
    for (int j = 0; j < 4; j++) begin
      zr = (md[j] == 1) ? 3 : 2;
      wreg(`PWST_OFF_CLEAR, 32'h7fff);
      wreg(`PWST_OFF_CTRL, 32'h1 | (md[j] << 2));
      trap_n <= 1'b0;
      cyc(6);
      rchk(`PWST_OFF_STATUS, 16'h0c00);
      chk({9'h000, pin}, exp_pin(main_outputs_passive_level, 7'h00));
      trap_n <= 1'b1;
      cyc(6);
      pulse(5 - zr);
      rchk(`PWST_OFF_STATUS, md[j] == 3 ? 16'h0000 : 16'h0800);
      pulse(zr);
      rchk(`PWST_OFF_STATUS, md[j] == 2 ? 16'h0800 : 16'h0000);
    end
    // reserved code leaves the trap state stuck, so reset in mid-run
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    wreg(`PWST_OFF_CTRL, 32'h0010);
    wreg(`PWST_OFF_OUTCFG, 32'h002a);
    cyc(2);
    chk({10'h000, pat}, 16'h002a);
    hall_w <= 1'b1;
    cyc(6);
    rchk(`PWST_OFF_STATUS, 16'h6000);
    chk({10'h000, pat}, 16'h0000);
    wreg(`PWST_OFF_CLEAR, 32'h6000);
    hall_c <= 1'b1;
    cyc(6);
    rchk(`PWST_OFF_STATUS, 16'h1000);
    test_done();
  end
endmodule // pwm_unit_status_and_output_level_tb_top
`default_nettype wire
